/* File: bridge_ext_params.svh */
/*
  Offsets, field positions, reset values and counts for the bridge
  extension configuration registers.
  Assumes configuration accesses present a dword address plus byte lanes.
*/
`ifndef BRIDGE_EXT_PARAMS_SVH
`define BRIDGE_EXT_PARAMS_SVH

// Byte offsets of the registers in configuration space
`define CHIP_CTL_OFFSET       8'h40
`define DIAG_OFFSET           8'h41
`define ARB_CTL_OFFSET        8'h42
`define SERR_DIS_OFFSET       8'h64

// Dword addresses (byte offset divided by four)
`define DW_EXT_CONTROL        6'h10
`define DW_SERR_DISABLE       6'h19

// Reset values and writable-bit masks
`define CHIP_CTL_RESET        8'h00
`define CHIP_CTL_WMASK        8'h32
`define DIAG_READ_VALUE       8'h00
`define ARB_CTL_RESET         16'h0200
`define ARB_CTL_WMASK         16'h03ff
`define SERR_DIS_RESET        8'h00
`define SERR_DIS_WMASK        8'h7e

// Chip control fields
`define CHIP_PIN_GATE_BIT     5
`define CHIP_PREFETCH_BIT     4
`define CHIP_LINE_DISC_BIT    1

// Diagnostic field
`define DIAG_BRIDGE_RESET_BIT 0

// Arbiter control fields
`define ARB_BRIDGE_TIER_BIT   9
`define ARB_REQUESTERS        10

// System-error event disable fields
`define SERR_PW_PARITY_BIT    1
`define SERR_PW_TIMEOUT_BIT   2
`define SERR_PW_TABORT_BIT    3
`define SERR_PW_MABORT_BIT    4
`define SERR_DW_TIMEOUT_BIT   5
`define SERR_DR_TIMEOUT_BIT   6

// Length of the internal bridge reset, in clock cycles
`define INTERNAL_RESET_CYCLES 4

`endif

/* File: bridge_ext_pkg.sv */
/*
  Types shared by the bridge extension register block.
  Assumes nothing of its surroundings.
*/
package bridge_ext_pkg;

  // Diagnostic reset sequence, one-hot
  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b001,
    SEQ_SET_SEC = 3'b010,
    SEQ_INT_RST = 3'b100
  } reset_seq_t;

endpackage : bridge_ext_pkg

/* File: reset_sequencer.sv */
/*
  Diagnostic reset sequencer: on a trigger, first pulses a request to set
  the secondary reset bit, then holds an internal reset for a fixed count.
  Assumes the trigger is a one-cycle pulse in the same clock domain.
*/
`include "bridge_ext_params.svh"

module reset_sequencer #(
  parameter int RESET_CYCLES = `INTERNAL_RESET_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic ce,
  // Trigger from the diagnostic register
  input  wire logic trigger,
  // Sequence outputs
  output logic      secResetSet,
  output logic      internalReset
);

  localparam int CW = $clog2(RESET_CYCLES + 1);

  bridge_ext_pkg::reset_seq_t state_r;
  logic [CW-1:0]              count_r;

  // Sequence: secondary reset set strictly before the internal reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r       <= bridge_ext_pkg::SEQ_IDLE;
      count_r       <= '0;
      secResetSet   <= 1'b0;
      internalReset <= 1'b0;
    end else if (ce) begin
      case (state_r)
        bridge_ext_pkg::SEQ_IDLE: begin
          internalReset <= 1'b0;
          if (trigger) begin
            state_r     <= bridge_ext_pkg::SEQ_SET_SEC;
            secResetSet <= 1'b1;
          end
        end
        bridge_ext_pkg::SEQ_SET_SEC: begin
          secResetSet   <= 1'b0;
          internalReset <= 1'b1;
          count_r       <= CW'(RESET_CYCLES - 1);
          state_r       <= bridge_ext_pkg::SEQ_INT_RST;
        end
        bridge_ext_pkg::SEQ_INT_RST: begin
          if (count_r == '0) begin
            internalReset <= 1'b0;
            state_r       <= bridge_ext_pkg::SEQ_IDLE;
          end else begin
            count_r <= count_r - 1'b1;
          end
        end
        default: begin
          state_r       <= bridge_ext_pkg::SEQ_IDLE;
          secResetSet   <= 1'b0;
          internalReset <= 1'b0;
        end
      endcase
    end
  end

endmodule : reset_sequencer

/* File: bridge_ext_regs.sv */
/*
  Extension configuration registers of a two-port bridge: chip control,
  diagnostic reset, two-tier arbiter control with its arbiter, and the
  primary system-error event disable register.
  Assumes configuration cycles arrive as single-cycle strobes with a dword
  address and byte enables, and that the bridge control register holding
  the secondary reset bit lives elsewhere and is set by a pulse.

  // Behaviour
  // - Chip control at 40h, resets 00h, mixed.
  // - Gate bit clear: forward per command enables.
  // - Gate bit set: pin 3 high stops forwarding.
  // - Bit 4 enables upstream prefetch, off at reset.
  // - Bit 1 adds cache-line write disconnects.
  // - Chip control bits 7,6,3,2,0 read zero.
  // - Diagnostic at 41h, resets 00h, 7-1 zero.
  // - Diagnostic bit 0: secondary reset, then reset.
  // - Internal reset spares bridge control bit 6.
  // - Diagnostic bit 0 write-only, self-clearing.
  // - Arbiter: two tiers, rotating within each.
  // - Arbiter control at 42h, resets 0200h.
  // - Bit 9 puts bridge in high tier.
  // - Bits 8-0 tier each secondary grant line.
  // - Event disable at 64h, resets 00h.
  // - Event disable bits 7,0 read-only, 6-1 writable.
  // - Bits 1,3,4 mask posted write errors.
  // - Bits 2,5,6 mask retry time-outs.
*/
`include "bridge_ext_params.svh"

module bridge_ext_regs #(
  parameter int RESET_CYCLES = `INTERNAL_RESET_CYCLES,
  parameter int REQUESTERS   = `ARB_REQUESTERS
) (
  // Clock, reset and enable
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Configuration access
  input  wire logic [5:0]  cfgDword,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [31:0] cfgWriteData,
  output logic [31:0]      cfgReadData,
  output logic             cfgReadValid,
  // Command register enables and pin
  input  wire logic        ioSpaceEnable,
  input  wire logic        memSpaceEnable,
  input  wire logic        serrEnable,
  input  wire logic        general_pin_3,
  // Forwarding controls
  output logic             ioForwardEnable,
  output logic             memForwardEnable,
  output logic             upstreamPrefetch,
  output logic             lineDisconnect,
  // Diagnostic reset
  output logic             secResetSet,
  output logic             bridgeInternalReset,
  // Secondary arbiter
  input  wire logic [8:0]  secondaryRequest,
  input  wire logic        bridgeRequest,
  output logic [8:0]       secondaryGrant,
  output logic             bridgeGrant,
  // System-error events, one-cycle pulses
  input  wire logic        pwParityError,
  input  wire logic        pwTimeout,
  input  wire logic        pwTargetAbort,
  input  wire logic        pwMasterAbort,
  input  wire logic        dwTimeout,
  input  wire logic        drTimeout,
  output logic             primary_system_error
);

  localparam int IW = $clog2(REQUESTERS);

  logic [7:0]            chipCtl_r;
  logic [15:0]           arbCtl_r;
  logic [7:0]            serrDis_r;
  logic                  pinMeta_r;
  logic                  pinSync2_r;
  logic                  pinSync3_r;
  logic                  pinHigh_r;
  logic                  regClear;
  logic                  ctlWrite;
  logic                  serrWrite;
  logic                  diagTrigger;
  logic [REQUESTERS-1:0] request;
  logic [REQUESTERS-1:0] grant_r;
  logic [REQUESTERS-1:0] grant_nxt;
  logic [REQUESTERS-1:0] highReq;
  logic [REQUESTERS-1:0] lowReq;
  logic [IW-1:0]         lastHigh_r;
  logic [IW-1:0]         lastLow_r;
  logic [IW-1:0]         lastHigh_nxt;
  logic [IW-1:0]         lastLow_nxt;
  logic                  serrEvent;

  // Rotating pick starting just after the last winner
  function automatic logic [REQUESTERS-1:0] rotatePick(
    input logic [REQUESTERS-1:0] req,
    input logic [IW-1:0]         last
  );
    logic [REQUESTERS-1:0] pick;
    logic                  found;
    int                    idx;
    pick  = '0;
    found = 1'b0;
    for (int k = 1; k <= REQUESTERS; k++) begin
      idx = (int'(last) + k) % REQUESTERS;
      if (!found && req[idx]) begin
        pick[idx] = 1'b1;
        found     = 1'b1;
      end
    end
    return pick;
  endfunction : rotatePick

  // Index of the set bit of a one-hot vector
  function automatic logic [IW-1:0] oneHotIndex(
    input logic [REQUESTERS-1:0] vec
  );
    logic [IW-1:0] idx;
    idx = '0;
    for (int k = 0; k < REQUESTERS; k++) begin
      if (vec[k]) begin
        idx = IW'(k);
      end
    end
    return idx;
  endfunction : oneHotIndex

  // Merge write data into a register through byte lanes and a mask
  function automatic logic [7:0] laneMerge(
    input logic [7:0] old,
    input logic [7:0] data,
    input logic [7:0] mask
  );
    return (old & ~mask) | (data & mask);
  endfunction : laneMerge

  // Address decode of configuration writes
  assign ctlWrite    = cfgWrite && (cfgDword == `DW_EXT_CONTROL);
  assign serrWrite   = cfgWrite && (cfgDword == `DW_SERR_DISABLE);
  assign diagTrigger = ctlWrite && cfgByteEn[1]
                       && cfgWriteData[8 + `DIAG_BRIDGE_RESET_BIT];
  // Internal reset clears these registers; bit 6 outside is spared
  assign regClear    = !resetn || bridgeInternalReset;

  // Diagnostic sequence: secondary reset pulse, then internal reset
  reset_sequencer #(
    .RESET_CYCLES (RESET_CYCLES)
  ) u_reset_sequencer (
    .clock         (clock),
    .resetn        (resetn),
    .ce            (ce),
    .trigger       (diagTrigger),
    .secResetSet   (secResetSet),
    .internalReset (bridgeInternalReset)
  );

  // Chip control, writable bits 5, 4 and 1 only
  always_ff @(posedge clock) begin
    if (regClear) begin
      chipCtl_r <= `CHIP_CTL_RESET;
    end else if (ce && ctlWrite && cfgByteEn[0]) begin
      chipCtl_r <= laneMerge(chipCtl_r, cfgWriteData[7:0],
                             `CHIP_CTL_WMASK);
    end
  end

  // Arbiter control, bits 15-10 stay zero
  always_ff @(posedge clock) begin
    if (regClear) begin
      arbCtl_r <= `ARB_CTL_RESET;
    end else if (ce && ctlWrite) begin
      if (cfgByteEn[2]) begin
        arbCtl_r[7:0] <= laneMerge(arbCtl_r[7:0], cfgWriteData[23:16],
                                   8'(`ARB_CTL_WMASK));
      end
      if (cfgByteEn[3]) begin
        arbCtl_r[15:8] <= laneMerge(arbCtl_r[15:8], cfgWriteData[31:24],
                                    8'((`ARB_CTL_WMASK) >> 8));
      end
    end
  end

  // Event disable, bits 7 and 0 read-only
  always_ff @(posedge clock) begin
    if (regClear) begin
      serrDis_r <= `SERR_DIS_RESET;
    end else if (ce && serrWrite && cfgByteEn[0]) begin
      serrDis_r <= laneMerge(serrDis_r, cfgWriteData[7:0],
                             `SERR_DIS_WMASK);
    end
  end

  // Read path; diagnostic lane always reads zero, other dwords zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfgReadData  <= 32'h00000000;
      cfgReadValid <= 1'b0;
    end else if (ce) begin
      cfgReadValid <= cfgRead;
      if (cfgRead) begin
        case (cfgDword)
          `DW_EXT_CONTROL: begin
            cfgReadData <= {arbCtl_r, `DIAG_READ_VALUE, chipCtl_r};
          end
          `DW_SERR_DISABLE: begin
            cfgReadData <= {24'h000000, serrDis_r};
          end
          default: begin
            cfgReadData <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // Pin synchroniser; level accepted once stages two and three agree
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pinMeta_r  <= 1'b0;
      pinSync2_r <= 1'b0;
      pinSync3_r <= 1'b0;
      pinHigh_r  <= 1'b0;
    end else if (ce) begin
      pinMeta_r  <= general_pin_3;
      pinSync2_r <= pinMeta_r;
      pinSync3_r <= pinSync2_r;
      if (pinSync2_r == pinSync3_r) begin
        pinHigh_r <= pinSync3_r;
      end
    end
  end

  // Forwarding and transaction policy outputs
  always_ff @(posedge clock) begin
    if (regClear) begin
      ioForwardEnable  <= 1'b0;
      memForwardEnable <= 1'b0;
      upstreamPrefetch <= 1'b0;
      lineDisconnect   <= 1'b0;
    end else if (ce) begin
      if (chipCtl_r[`CHIP_PIN_GATE_BIT] && pinHigh_r) begin
        ioForwardEnable  <= 1'b0;
        memForwardEnable <= 1'b0;
      end else begin
        ioForwardEnable  <= ioSpaceEnable;
        memForwardEnable <= memSpaceEnable;
      end
      upstreamPrefetch <= chipCtl_r[`CHIP_PREFETCH_BIT];
      lineDisconnect   <= chipCtl_r[`CHIP_LINE_DISC_BIT];
    end
  end

  // Bridge is requester 9; tier mask is the low ten control bits
  assign request = {bridgeRequest, secondaryRequest};
  assign highReq = request & arbCtl_r[9:0];
  assign lowReq  = request & ~arbCtl_r[9:0];

  // Grant parks on a live requester, else high tier beats low tier
  always_comb begin
    grant_nxt    = grant_r;
    lastHigh_nxt = lastHigh_r;
    lastLow_nxt  = lastLow_r;
    if ((grant_r & request) == '0) begin
      if (highReq != '0) begin
        grant_nxt    = rotatePick(highReq, lastHigh_r);
        lastHigh_nxt = oneHotIndex(grant_nxt);
      end else if (lowReq != '0) begin
        grant_nxt   = rotatePick(lowReq, lastLow_r);
        lastLow_nxt = oneHotIndex(grant_nxt);
      end else begin
        grant_nxt = '0;
      end
    end
  end

  // Arbiter state; grants drop during an internal reset
  always_ff @(posedge clock) begin
    if (regClear) begin
      grant_r    <= '0;
      lastHigh_r <= IW'(REQUESTERS - 1);
      lastLow_r  <= IW'(REQUESTERS - 1);
    end else if (ce) begin
      grant_r    <= grant_nxt;
      lastHigh_r <= lastHigh_nxt;
      lastLow_r  <= lastLow_nxt;
    end
  end

  assign secondaryGrant = grant_r[8:0];
  assign bridgeGrant    = grant_r[9];

  // Events gated by their disable bits and the command enable
  assign serrEvent =
    (pwParityError && !serrDis_r[`SERR_PW_PARITY_BIT])   ||
    (pwTargetAbort && !serrDis_r[`SERR_PW_TABORT_BIT])   ||
    (pwMasterAbort && !serrDis_r[`SERR_PW_MABORT_BIT])   ||
    (pwTimeout     && !serrDis_r[`SERR_PW_TIMEOUT_BIT])  ||
    (dwTimeout     && !serrDis_r[`SERR_DW_TIMEOUT_BIT])  ||
    (drTimeout     && !serrDis_r[`SERR_DR_TIMEOUT_BIT]);

  // One-cycle system-error request toward the primary pin logic
  always_ff @(posedge clock) begin
    if (regClear) begin
      primary_system_error <= 1'b0;
    end else if (ce) begin
      primary_system_error <= serrEvent && serrEnable;
    end
  end

endmodule : bridge_ext_regs

/* File: bridge_ext_regs_asserts.sv */
/* Checker bound to bridge_ext_regs, seeing only its ports.
   Assumes ce stays high while the checks matter. */
`include "bridge_ext_params.svh"

module bridge_ext_regs_asserts #(
  parameter int RESET_CYCLES = 4
) (
  // Clock and control
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        ce,
  // Configuration access
  input wire logic [5:0]  cfgDword,
  input wire logic [3:0]  cfgByteEn,
  input wire logic        cfgWrite,
  input wire logic        cfgRead,
  input wire logic [31:0] cfgWriteData,
  input wire logic [31:0] cfgReadData,
  input wire logic        cfgReadValid,
  // Forwarding and events
  input wire logic        ioSpaceEnable,
  input wire logic        ioForwardEnable,
  input wire logic        serrEnable,
  input wire logic        pwParityError,
  input wire logic        pwTimeout,
  input wire logic        pwTargetAbort,
  input wire logic        pwMasterAbort,
  input wire logic        dwTimeout,
  input wire logic        drTimeout,
  input wire logic        primary_system_error,
  // Diagnostic reset and arbiter
  input wire logic        secResetSet,
  input wire logic        bridgeInternalReset,
  input wire logic [8:0]  secondaryRequest,
  input wire logic        bridgeRequest,
  input wire logic [8:0]  secondaryGrant,
  input wire logic        bridgeGrant
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // Any event pulse at all
  wire anyEvent = pwParityError | pwTimeout | pwTargetAbort |
    pwMasterAbort | dwTimeout | drTimeout;

  // Cycles the internal reset has stood; a counter keeps repetition short
  logic [3:0] runLen_r;
  always_ff @(posedge clock) begin
    if (!resetn || !bridgeInternalReset) begin
      runLen_r <= 4'h0;
    end else if (ce) begin
      runLen_r <= runLen_r + 4'h1;
    end
  end

  // Diagnostic write that is not a retrigger of a busy sequence
  sequence diagWrite;
    ce && cfgWrite && cfgDword == `DW_EXT_CONTROL && cfgByteEn[1] &&
      cfgWriteData[8] && !secResetSet && !bridgeInternalReset;
  endsequence
  sequence secThenReset;
    secResetSet ##1 (bridgeInternalReset && !secResetSet);
  endsequence

  diag_order_a: assert property (diagWrite |=> secThenReset)
    else $error("diagnostic sequence out of order");
  reset_len_a: assert property ($fell(bridgeInternalReset) |->
    runLen_r == RESET_CYCLES) else $error("internal reset length");
  sec_cause_a: assert property (secResetSet |-> $past(cfgWrite) &&
    $past(cfgWriteData[8]) && $past(cfgByteEn[1]))
    else $error("secondary reset without diagnostic write");
  read_valid_a: assert property (ce |=>
    cfgReadValid == $past(cfgRead)) else $error("read valid timing");
  chip_ro_a: assert property (ce && cfgRead &&
    cfgDword == `DW_EXT_CONTROL |=> (cfgReadData & 32'hfc00ffcd) == 32'h0)
    else $error("reserved control bits nonzero");
  serr_ro_a: assert property (ce && cfgRead &&
    cfgDword == `DW_SERR_DISABLE |=> (cfgReadData & 32'hffffff81) == 32'h0)
    else $error("reserved disable bits nonzero");
  unmapped_a: assert property (ce && cfgRead &&
    cfgDword != `DW_EXT_CONTROL && cfgDword != `DW_SERR_DISABLE
    |=> cfgReadData == 32'h0) else $error("unmapped read nonzero");
  serr_quiet_a: assert property (ce && !(serrEnable && anyEvent)
    |=> !primary_system_error) else $error("system error without event");
  grant_onehot_a: assert property ($onehot0({bridgeGrant,
    secondaryGrant})) else $error("several grants");
  grant_req_a: assert property (ce |=>
    (secondaryGrant & ~$past(secondaryRequest)) == 9'h0 &&
    !(bridgeGrant && !$past(bridgeRequest))) else $error("grant no request");
  grant_busy_a: assert property (ce && !bridgeInternalReset &&
    (bridgeRequest || secondaryRequest != 9'h0) |=>
    bridgeGrant || secondaryGrant != 9'h0) else $error("request starved");
  fwd_cmd_a: assert property (!ioSpaceEnable ##1 !ioSpaceEnable
    |-> !ioForwardEnable) else $error("forwarding without enable");
endmodule : bridge_ext_regs_asserts

bind bridge_ext_regs bridge_ext_regs_asserts #(
  .RESET_CYCLES(RESET_CYCLES)
) u_chk (.*);

/* File: cfg_host.sv */
/* Configuration host model that drives the register access port.
   Assumes each access is entered just after a rising edge. */
module cfg_host (
  // Clock
  input  wire logic        clock,
  // Access strobes
  output logic [5:0]       cfgDword,
  output logic [3:0]       cfgByteEn,
  output logic             cfgWrite,
  output logic             cfgRead,
  output logic [31:0]      cfgWriteData,
  // Read answer
  input  wire logic [31:0] cfgReadData,
  input  wire logic        cfgReadValid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {cfgDword, cfgByteEn, cfgWriteData} = '0;
    {cfgWrite, cfgRead} = 2'b00;
  end

  // One-cycle strobe; released lines go inverted so stale data misleads
  task automatic xfer(input logic wr, input logic [5:0] dw,
                      input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q);
    {cfgDword, cfgByteEn, cfgWriteData} = {dw, be, d};
    {cfgWrite, cfgRead} = {wr, !wr};
    @(posedge clock);
    #1;
    q = (cfgReadValid === 1'b1) ? cfgReadData : 32'hx;
    {cfgWrite, cfgRead} = 2'b00;
    {cfgDword, cfgByteEn, cfgWriteData} = ~{dw, be, d};
    @(posedge clock);
    #1;
  endtask : xfer
endmodule : cfg_host

/* File: bridge_ext_regs_tb.sv */
/* Self-checking bench for bridge_ext_regs with a host model.
   Assumes the checker binds itself from its own file. */
`include "bridge_ext_params.svh"

module bridge_ext_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RC = 3;

  // Design ports
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic [5:0]  cfgDword;
  logic [3:0]  cfgByteEn;
  logic        cfgWrite, cfgRead, cfgReadValid;
  logic [31:0] cfgWriteData, cfgReadData;
  logic        ioSpaceEnable = 1'b0;
  logic        memSpaceEnable = 1'b0;
  logic        serrEnable = 1'b0;
  logic        general_pin_3 = 1'b0;
  logic        ioForwardEnable, memForwardEnable;
  logic        upstreamPrefetch, lineDisconnect;
  logic        secResetSet, bridgeInternalReset;
  logic [8:0]  secondaryRequest = 9'h000;
  logic        bridgeRequest = 1'b0;
  logic [8:0]  secondaryGrant;
  logic        bridgeGrant, primary_system_error;
  logic [5:0]  ev = 6'h00;
  // Bench state and arbiter table
  int          fails = 0;
  int          cmp_count = 0;
  int          seed = 65930;
  logic [31:0] d, q;
  logic [7:0]  chipExp = 8'h00;
  logic [7:0]  serrExp = 8'h00;
  logic [15:0] arbExp = 16'h0200;
  logic [15:0] arbTab [4] = '{16'h0200, 16'h0008, 16'h0008, 16'h0008};
  logic [9:0]  reqTab [4] = '{10'h208, 10'h208, 10'h003, 10'h003};
  logic [9:0]  gntTab [4] = '{10'h200, 10'h008, 10'h001, 10'h002};

  bridge_ext_regs #(.RESET_CYCLES(RC)) u_dut (
    .*,
    .pwParityError(ev[0]), .pwTimeout(ev[1]), .pwTargetAbort(ev[2]),
    .pwMasterAbort(ev[3]), .dwTimeout(ev[4]), .drTimeout(ev[5])
  );
  cfg_host u_host (.*);

  always #5 clock = ~clock;

  // Expected word at the extension control dword
  function automatic logic [31:0] ctlWord();
    return {arbExp, 8'h00, chipExp};
  endfunction : ctlWord

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Read both registers and the control copies back
  task automatic read_all(input string t);
    u_host.xfer(1'b0, `DW_EXT_CONTROL, 4'hf, 32'h0, q);
    check("ext control", q, ctlWord());
    u_host.xfer(1'b0, `DW_SERR_DISABLE, 4'hf, 32'h0, q);
    check("event disable", q, {24'h0, serrExp});
    check("prefetch", 32'(upstreamPrefetch), 32'(chipExp[4]));
    check("disconnect", 32'(lineDisconnect), 32'(chipExp[1]));
    $display("test %s done", t);
  endtask : read_all

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    close_out();
  end

  initial begin
    tick(3);
    resetn = 1'b1;
    read_all("reset");
    // Random writes; all-ones corner first; diag lane kept off
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hffffffff : $random(seed);
      u_host.xfer(1'b1, `DW_EXT_CONTROL, 4'hd, d, q);
      u_host.xfer(1'b1, `DW_SERR_DISABLE, 4'hf, ~d, q);
      u_host.xfer(1'b1, 6'h11, 4'hf, d, q);
      u_host.xfer(1'b0, 6'h11, 4'hf, 32'h0, q);
      check("unmapped", q, 32'h0);
      chipExp = d[7:0] & 8'h32;
      arbExp = d[31:16] & 16'h03ff;
      serrExp = ~d[7:0] & 8'h7e;
      read_all("random");
    end
    // Every gate, pin and command enable combination
    for (int i = 0; i < 16; i++) begin
      {general_pin_3, ioSpaceEnable, memSpaceEnable} = i[2:0];
      chipExp = {2'b00, i[3], 5'h00};
      u_host.xfer(1'b1, `DW_EXT_CONTROL, 4'h1, {24'h0, chipExp}, q);
      tick(8);
      check("io fwd", 32'(ioForwardEnable), 32'(i[1] & !(i[3] & i[2])));
      check("memfwd", 32'(memForwardEnable), 32'(i[0] & !(i[3] & i[2])));
    end
    // Each event alone enabled, then alone disabled
    serrEnable = 1'b1;
    for (int i = 0; i < 12; i++) begin
      serrExp = (i < 6) ? ~(8'h02 << i) & 8'h7e : 8'h02 << (i - 6);
      u_host.xfer(1'b1, `DW_SERR_DISABLE, 4'h1, {24'h0, serrExp}, q);
      ev = 6'h01 << (i % 6);
      tick(1);
      ev = 6'h00;
      check("system error", 32'(primary_system_error), 32'(i < 6));
    end
    // Tier placement and rotation, idle between rows
    for (int i = 0; i < 4; i++) begin
      arbExp = arbTab[i];
      u_host.xfer(1'b1, `DW_EXT_CONTROL, 4'hc, {arbExp, 16'h0}, q);
      {bridgeRequest, secondaryRequest} = reqTab[i];
      tick(2);
      q = 32'({bridgeGrant, secondaryGrant});
      check("grant", q, 32'(gntTab[i]));
      {bridgeRequest, secondaryRequest} = 10'h000;
      tick(2);
    end
    for (int i = 0; i < 40; i++) begin
      d = $random(seed);
      {bridgeRequest, secondaryRequest} = d[9:0];
      tick(1);
    end
    {bridgeRequest, secondaryRequest} = 10'h000;
    read_all("arbiter");
    // Clock enable low: a write in that window must not land
    ce = 1'b0;
    u_host.xfer(1'b1, `DW_SERR_DISABLE, 4'h1, 32'h0000007e, q);
    ce = 1'b1;
    read_all("freeze");
    // Diagnostic reset: pulse first, then fixed-length internal reset
    // The pulse stands only in the cycle after the write edge
    fork
      u_host.xfer(1'b1, `DW_EXT_CONTROL, 4'h2, 32'h00000100, q);
      begin
        tick(1);
        check("sec reset", 32'(secResetSet), 32'h1);
      end
    join
    for (int k = 0; k < RC; k++) begin
      check("int reset", 32'(bridgeInternalReset), 32'h1);
      tick(1);
    end
    check("int reset end", 32'(bridgeInternalReset), 32'h0);
    {chipExp, serrExp, arbExp} = {8'h00, 8'h00, 16'h0200};
    read_all("diagnostic");
    close_out();
  end
endmodule : bridge_ext_regs_tb
